// ### hw/pfs_device.sv
// Device end: register file, status pin, reference divider, mute.
// Assumes flags and reference clock are levels from analog logic.
`timescale 1ns/1ps
`include "pfs_regs.svh"
module pfs_device
#(
   parameter int RDIV_W = 5 // Reference divider width
)
(
   input wire logic clk_i, // 40 MHz clock
   input wire logic reset_i, // Async reset, high
   pfs_link_if.dev link, // Serial link
   input wire logic out_of_lock_flag_i, // Lock lost
   input wire logic in_lock_flag_i, // Locked
   input wire logic high_clamp_flag_i, // Pump at high clamp
   input wire logic low_clamp_flag_i, // Pump at low clamp
   input wire logic mute_n_i, // RF mute, active low
   input wire logic ref_clk_i, // Reference input
   output logic status_o, // Status pin
   output logic rf_enable_o, // RF outputs active
   output logic bias_enable_o, // Output bias kept on
   output logic modulator_enable_o, // Delta-sigma running
   output logic [1:0] ref_lowpass_select_o, // Buffer filter code
   output logic ref_gain_boost_o, // Buffer boost
   output logic pfd_ref_o // Divided reference pulse
);
   logic [2:0] cs_s, ck_s, di_s, mu_s, rf_s;
   logic [3:0] flag_q;
   logic [3:0] flag_s;
   logic [4:0] cnt_q;
   logic [15:0] sh_q;
   logic [7:0] tx_q;
   logic rd_q;
   logic [RDIV_W-1:0] rdiv_q;
   logic [RDIV_W-1:0] rcnt_q;
   logic [7:0] refbuf_q, mode_q, statsel_q;
   logic [7:0] rd_val;
   logic ck_rise, ck_fall, cs_act;

   // Two-flop synchronisers; third stage only feeds edge finders
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cs_s <= 3'h7;
         ck_s <= 3'h0;
         di_s <= 3'h0;
         mu_s <= 3'h7;
         rf_s <= 3'h0;
      end
      else
      begin
         cs_s <= {cs_s[1:0], link.cs_n};
         ck_s <= {ck_s[1:0], link.sclk};
         di_s <= {di_s[1:0], link.sdi};
         mu_s <= {mu_s[1:0], mute_n_i};
         rf_s <= {rf_s[1:0], ref_clk_i};
      end
   end

   assign cs_act = ~cs_s[1];
   assign ck_rise = ck_s[1] & ~ck_s[2];
   assign ck_fall = ~ck_s[1] & ck_s[2];

   // Readback mux; status register shows the live flags
   always_comb
   begin
      case (sh_q[7:1])
         `PFS_ADDR_STATUS: rd_val = {4'h0, flag_q};
         `PFS_ADDR_RDIV: rd_val = {{(8-RDIV_W){1'b0}}, rdiv_q};
         `PFS_ADDR_REFBUF: rd_val = refbuf_q;
         `PFS_ADDR_MODE: rd_val = mode_q;
         `PFS_ADDR_STATSEL: rd_val = statsel_q;
         default: rd_val = 8'h00;
      endcase
   end

   // Burst shifter; a burst ends with chip select, partial frames drop
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cnt_q <= 5'h00;
         sh_q <= 16'h0000;
         tx_q <= 8'h00;
         rd_q <= 1'b0;
         rdiv_q <= `PFS_RDIV_RST;
         refbuf_q <= `PFS_REFBUF_RST;
         mode_q <= `PFS_MODE_RST;
         statsel_q <= `PFS_STATSEL_RST;
      end
      else if (!cs_act)
      begin
         cnt_q <= 5'h00;
         rd_q <= 1'b0;
      end
      else if (ck_rise && cnt_q < 5'd16)
      begin
         sh_q <= {sh_q[14:0], di_s[1]};
         cnt_q <= cnt_q + 5'h01;
         if (cnt_q == 5'd15)
         begin
            if (!sh_q[7])
            begin
               case (sh_q[14:8])
                  `PFS_ADDR_RDIV:
                     if (|sh_q[RDIV_W-2:0] || di_s[1])
                        rdiv_q <= {sh_q[RDIV_W-2:0], di_s[1]};
                  `PFS_ADDR_REFBUF: refbuf_q <= {sh_q[6:0], di_s[1]};
                  `PFS_ADDR_MODE: mode_q <= {sh_q[6:0], di_s[1]};
                  `PFS_ADDR_STATSEL: statsel_q <= {sh_q[6:0], di_s[1]};
                  default: ;
               endcase
            end
         end
      end
      else if (ck_fall && cnt_q == 5'd8)
      begin
         rd_q <= sh_q[0];
         tx_q <= rd_val;
      end
      else if (ck_fall && rd_q && cnt_q > 5'd8)
         tx_q <= {tx_q[6:0], 1'b0};
   end

   assign link.sdo = tx_q[7];
   // Release after the last rise, before the synced deselect arrives
   assign link.sdo_oe_n = ~(cs_act & rd_q & (cnt_q < 5'd16));

   // Flag capture and status OR through per-flag enables
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         flag_s <= 4'h0;
         flag_q <= 4'h0;
         status_o <= 1'b0;
      end
      else
      begin
         flag_s <= {low_clamp_flag_i, high_clamp_flag_i, in_lock_flag_i,
            out_of_lock_flag_i};
         flag_q <= flag_s;
         status_o <= |(flag_q & statsel_q[3:0]);
      end
   end

   // Reference divider; ratio change takes effect at the next reference rise
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rcnt_q <= '0;
         pfd_ref_o <= 1'b0;
      end
      else
      begin
         pfd_ref_o <= 1'b0;
         if (rf_s[1] & ~rf_s[2])
         begin
            if (rcnt_q + RDIV_W'(1) >= rdiv_q)
            begin
               rcnt_q <= '0;
               pfd_ref_o <= 1'b1;
            end
            else
               rcnt_q <= rcnt_q + RDIV_W'(1);
         end
      end
   end

   // Mute gates only the outputs, so bias stays up for fast recovery
   assign rf_enable_o = mu_s[1] & ~mode_q[`PFS_MUTE_BIT];
   assign bias_enable_o = 1'b1;
   assign modulator_enable_o = ~mode_q[`PFS_INTN_BIT];
   assign ref_lowpass_select_o = refbuf_q[`PFS_FILT_LSB +: 2];
   assign ref_gain_boost_o = refbuf_q[`PFS_BOOST_BIT];
endmodule

// ### hw/pfs_regs.svh
// Constants for the synthesizer control block and its serial host.
// Assumes a single 40 MHz clock and a host-made serial clock.
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH
`define PFS_ADDR_STATUS 7'h00
`define PFS_ADDR_RDIV 7'h06
`define PFS_ADDR_REFBUF 7'h0B
`define PFS_ADDR_MODE 7'h0D
`define PFS_ADDR_STATSEL 7'h0E
`define PFS_RDIV_RST 5'h01
`define PFS_FILT_LSB 0
`define PFS_BOOST_BIT 2
`define PFS_INTN_BIT 0
`define PFS_MUTE_BIT 1
`define PFS_REFBUF_RST 8'h00
`define PFS_MODE_RST 8'h00
`define PFS_STATSEL_RST 8'h00
`define PFS_SCLK_HALF 4
`endif

// ### hw/pfs_pkg.sv
// Types for the host end of the serial link.
// Assumes the header of constants is included where offsets are needed.
package pfs_pkg;
   typedef enum logic [1:0] {PFS_IDLE, PFS_SHIFT, PFS_DONE} pfs_host_e;
   typedef logic [7:0] pfs_byte_t;
endpackage

// ### hw/pfs_link_if.sv
// Serial link between the synthesizer control and its host.
// Assumes the bench resolves the data-out wire from its enable.
`timescale 1ns/1ps
interface pfs_link_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic sdo;
   logic sdo_oe_n;
   modport dev (input cs_n, input sclk, input sdi, output sdo,
      output sdo_oe_n);
   modport host (output cs_n, output sclk, output sdi, input sdo,
      input sdo_oe_n);
endinterface

// ### hw/pfs_host.sv
// Host end: writes or reads one register per burst.
// Assumes 16-bit frames: 7-bit address, read bit, 8 data bits, MSB first.
`timescale 1ns/1ps
`include "pfs_regs.svh"
module pfs_host
(
   input wire logic clk_i, // 40 MHz clock
   input wire logic reset_i, // Async reset, high
   input wire logic req_i, // Start a transfer
   input wire logic rd_i, // 1 read, 0 write
   input wire logic [6:0] addr_i, // Register address
   input wire logic [7:0] wdata_i, // Write data
   output logic busy_o, // Transfer running
   output logic done_o, // One-cycle end pulse
   output logic [7:0] rdata_o, // Read data
   pfs_link_if.host link // Serial link
);
   pfs_pkg::pfs_host_e state_q;
   logic [2:0] div_q;
   logic [4:0] bit_q;
   logic [15:0] sh_q;
   logic [7:0] rx_q;
   logic sclk_q;
   logic sdo_s1_q, sdo_s2_q;

   // Pin synchroniser for returned data
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sdo_s1_q <= 1'b0;
         sdo_s2_q <= 1'b0;
      end
      else
      begin
         sdo_s1_q <= link.sdo;
         sdo_s2_q <= sdo_s1_q;
      end
   end

   // Divider makes the serial clock; data changes on falls
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_q <= pfs_pkg::PFS_IDLE;
         div_q <= 3'h0;
         bit_q <= 5'h00;
         sh_q <= 16'h0000;
         rx_q <= 8'h00;
         sclk_q <= 1'b0;
         done_o <= 1'b0;
         rdata_o <= 8'h00;
      end
      else
      begin
         done_o <= 1'b0;
         case (state_q)
            pfs_pkg::PFS_IDLE:
            begin
               if (req_i)
               begin
                  sh_q <= {addr_i, rd_i, wdata_i};
                  bit_q <= 5'h00;
                  div_q <= 3'h0;
                  state_q <= pfs_pkg::PFS_SHIFT;
               end
            end
            pfs_pkg::PFS_SHIFT:
            begin
               if (div_q == 3'(`PFS_SCLK_HALF - 1))
               begin
                  div_q <= 3'h0;
                  sclk_q <= ~sclk_q;
                  if (sclk_q)
                  begin
                     // Falling edge: next bit valid before rise
                     sh_q <= {sh_q[14:0], 1'b0};
                     bit_q <= bit_q + 5'h01;
                     // Sample at end of high phase; sync lag fits
                     rx_q <= {rx_q[6:0], sdo_s2_q};
                     if (bit_q == 5'd15)
                        state_q <= pfs_pkg::PFS_DONE;
                  end
               end
               else
                  div_q <= div_q + 3'h1;
            end
            pfs_pkg::PFS_DONE:
            begin
               rdata_o <= rx_q;
               done_o <= 1'b1;
               state_q <= pfs_pkg::PFS_IDLE;
            end
            default: state_q <= pfs_pkg::PFS_IDLE;
         endcase
      end
   end

   assign busy_o = (state_q != pfs_pkg::PFS_IDLE);
   assign link.cs_n = (state_q != pfs_pkg::PFS_SHIFT);
   assign link.sclk = sclk_q;
   assign link.sdi = sh_q[15];
endmodule

// ### sim/pfs_sva.sv
// Checker on the serial link between host end and device end.
// Assumes one 40 MHz clock and a host-made serial clock.
`timescale 1ns/1ps
module pfs_sva
(
   input wire logic clk_i, // Clock
   input wire logic reset_i, // Reset, high
   input wire logic cs_n, // Chip select
   input wire logic sclk, // Serial clock
   input wire logic sdi, // Host data
   input wire logic sdo, // Device data
   input wire logic sdo_oe_n // Device drives, low
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic sclk_q;
   logic [4:0] rise_q;
   // Last serial clock level, for edge finding
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i) sclk_q <= 1'b0;
      else sclk_q <= sclk;
   end
   // Rises in the current burst; cleared while deselected
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i) rise_q <= 5'h00;
      else if (cs_n) rise_q <= 5'h00;
      else if (sclk && !sclk_q) rise_q <= rise_q + 5'h01;
   end
   sequence s_high_half;
      sclk [*4] ##1 !sclk;
   endsequence
   property p_oe_idle;
      cs_n |-> sdo_oe_n;
   endproperty
   property p_sclk_idle;
      cs_n |-> !sclk;
   endproperty
   property p_sdi_hold;
      sclk && sclk_q |-> $stable(sdi);
   endproperty
   property p_sdo_hold;
      sclk && sclk_q && !sdo_oe_n |-> $stable(sdo);
   endproperty
   property p_half;
      $rose(sclk) |-> s_high_half;
   endproperty
   property p_gap;
      $rose(cs_n) |=> cs_n;
   endproperty
   property p_count;
      $rose(cs_n) |-> rise_q == 5'h10;
   endproperty
   property p_oe_read;
      $fell(sdo_oe_n) |-> !cs_n && rise_q == 5'h08;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("data out driven outside burst");
   a_sclk_idle: assert property (p_sclk_idle)
      else $error("serial clock moves while deselected");
   a_sdi_hold: assert property (p_sdi_hold)
      else $error("host data moved while clock high");
   a_sdo_hold: assert property (p_sdo_hold)
      else $error("device data moved while clock high");
   a_half: assert property (p_half)
      else $error("serial clock high phase wrong");
   a_gap: assert property (p_gap)
      else $error("no idle gap between bursts");
   a_count: assert property (p_count)
      else $error("burst rise count wrong");
   a_oe_read: assert property (p_oe_read)
      else $error("read drive started at wrong bit");
endmodule

// ### sim/testbench.sv
// Bench: host end drives device end over the link, results checked.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "pfs_regs.svh"
module testbench;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic req_i = 1'b0;
   logic rd_i = 1'b0;
   logic [6:0] addr_i = 7'h00;
   logic [7:0] wdata_i = 8'h00;
   logic [3:0] flags = 4'h0;
   logic mute_n_i = 1'b1;
   logic ref_clk_i = 1'b0;
   logic busy_o, done_o, status_o, rf_enable_o, bias_enable_o;
   logic modulator_enable_o, ref_gain_boost_o, pfd_ref_o;
   logic [1:0] ref_lowpass_select_o;
   logic [7:0] rdata_o;
   int n_fail = 0;
   int total_checks = 0;
   int ref_cnt = 0;
   int cycles = 0;
   pfs_link_if link();
   pfs_host pfs_host_i (.clk_i, .reset_i, .req_i, .rd_i, .addr_i,
      .wdata_i, .busy_o, .done_o, .rdata_o, .link(link));
   pfs_device pfs_device_i (.clk_i, .reset_i, .link(link),
      .out_of_lock_flag_i(flags[0]), .in_lock_flag_i(flags[1]),
      .high_clamp_flag_i(flags[2]), .low_clamp_flag_i(flags[3]),
      .mute_n_i, .ref_clk_i, .status_o, .rf_enable_o, .bias_enable_o,
      .modulator_enable_o, .ref_lowpass_select_o, .ref_gain_boost_o,
      .pfd_ref_o);
   pfs_sva pfs_sva_i (.clk_i(clk_i), .reset_i(reset_i),
      .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi),
      .sdo(link.sdo), .sdo_oe_n(link.sdo_oe_n));
   // 40 MHz clock and an unrelated 200 ns reference
   always #12.5 clk_i = ~clk_i;
   always #100 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) ref_cnt++;
   // Hang guard, far above the few thousand cycles needed
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         conclude();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // One burst; a read compares its data with d
   task automatic acc(input logic rd, input logic [6:0] a,
      input logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk_i);
      req_i = 1'b1;
      rd_i = rd;
      addr_i = a;
      wdata_i = d;
      @(negedge clk_i);
      req_i = 1'b0;
      while (done_o !== 1'b1 && n < 400)
      begin
         @(negedge clk_i);
         n++;
      end
      if (n == 400) n_fail++;
      if (rd) chk(rdata_o, d);
      repeat (2) @(negedge clk_i);
   endtask
   // Reference edges between two divided pulses
   task automatic meas(input logic [7:0] r);
      int c0;
      do @(negedge clk_i); while (pfd_ref_o !== 1'b1);
      c0 = ref_cnt;
      @(negedge clk_i);
      do @(negedge clk_i); while (pfd_ref_o !== 1'b1);
      chk(8'(ref_cnt - c0), r);
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (4) @(negedge clk_i);
      acc(1'b1, `PFS_ADDR_RDIV, 8'h01);
      acc(1'b1, `PFS_ADDR_REFBUF, 8'h00);
      acc(1'b1, `PFS_ADDR_MODE, 8'h00);
      acc(1'b1, `PFS_ADDR_STATSEL, 8'h00);
      $display("reset test done");
      // Each flag alone: masked by the others, then enabled
      for (int i = 0; i < 4; i++)
      begin
         flags = 4'h1 << i;
         acc(1'b0, `PFS_ADDR_STATSEL, 8'h0F ^ (8'h01 << i));
         chk({7'h00, status_o}, 8'h00);
         acc(1'b0, `PFS_ADDR_STATSEL, 8'h01 << i);
         chk({7'h00, status_o}, 8'h01);
         acc(1'b1, `PFS_ADDR_STATUS, {4'h0, flags});
      end
      $display("status test done");
      // Every filter code with and without boost
      for (int c = 0; c < 8; c++)
      begin
         acc(1'b0, `PFS_ADDR_REFBUF, 8'(c));
         chk({5'h00, ref_gain_boost_o, ref_lowpass_select_o}, 8'(c));
         acc(1'b1, `PFS_ADDR_REFBUF, 8'(c));
      end
      // Integer-N, then pin mute keeps bias, then software mute
      acc(1'b0, `PFS_ADDR_MODE, 8'h01);
      chk({5'h00, modulator_enable_o, rf_enable_o, bias_enable_o}, 8'h03);
      acc(1'b0, `PFS_ADDR_MODE, 8'h00);
      chk({5'h00, modulator_enable_o, rf_enable_o, bias_enable_o}, 8'h07);
      mute_n_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk({5'h00, modulator_enable_o, rf_enable_o, bias_enable_o}, 8'h05);
      mute_n_i = 1'b1;
      repeat (3) @(negedge clk_i);
      chk({5'h00, modulator_enable_o, rf_enable_o, bias_enable_o}, 8'h07);
      acc(1'b0, `PFS_ADDR_MODE, 8'h02);
      chk({5'h00, modulator_enable_o, rf_enable_o, bias_enable_o}, 8'h05);
      acc(1'b0, `PFS_ADDR_MODE, 8'h00);
      $display("mode test done");
      // Divider at both ends of its range; zero is refused
      meas(8'h01);
      acc(1'b0, `PFS_ADDR_RDIV, 8'h1F);
      acc(1'b0, `PFS_ADDR_RDIV, 8'h00);
      acc(1'b1, `PFS_ADDR_RDIV, 8'h1F);
      meas(8'h1F);
      acc(1'b0, 7'h7F, 8'hAA);
      acc(1'b1, 7'h7F, 8'h00);
      $display("divider test done");
      conclude();
   end
endmodule
